// file: rtl/vcfg_consts.vh
// Purpose: shared constants of the volatile configuration block
// Assumes: single-line serial protocol, 3-byte addressing
// Notes:   field positions follow the volatile configuration byte
`ifndef VCFG_CONSTS_VH
`define VCFG_CONSTS_VH
// opcodes
`define OP_WR_VCFG      8'h81
`define OP_RD_VCFG      8'h85
`define OP_FAST_READ    8'h0B
`define OP_TUNE_READ    8'h5A
// configuration byte fields
`define DUMMY_MSB       7
`define DUMMY_LSB       4
`define IN_PLACE_BIT    3
`define RSVD_BIT        2
`define WRAP_MSB        1
`define WRAP_LSB        0
`define CFG_RESET       8'hFB
`define DUMMY_DEFAULT   4'h8
// wrap codes
`define WRAP_16         2'h0
`define WRAP_32         2'h1
`define WRAP_64         2'h2
`define WRAP_CONT       2'h3
// tuning byte repeated by the tuning read
`define TUNE_PATTERN    8'h5A
// frame phases
`define ADDR_BITS       5'h18
`define OP_BITS         5'h08
// pin idle levels: sck, csN, dq
`define PIN_IDLE        3'h2
`endif

// file: rtl/pin_sync.v
// Purpose: three-stage synchroniser with agreement filter for slow pins
// Assumes: pins change far slower than clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter       W    = 3,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // raw pins and filtered levels
  input  wire [W-1:0] pinRaw,
  output reg  [W-1:0] pinLevel_r
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // a change counts once stages two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r       <= INIT;
      s2_r       <= INIT;
      s3_r       <= INIT;
      pinLevel_r <= INIT;
    end else begin
      s1_r       <= pinRaw;
      s2_r       <= s1_r;
      s3_r       <= s2_r;
      pinLevel_r <= (s2_r & s3_r) | (pinLevel_r & (s2_r ^ s3_r));
    end
  end
endmodule
`default_nettype wire

// file: rtl/volatile_config_wrap_dummy.v
// Purpose: volatile configuration byte of a serial flash and the read
//          path it steers: dummy count, execute-in-place, read wrap
// Assumes: serial clock mode 0, clk at least 8x the serial clock
// Notes:   array data comes from memData one clk after memAddr changes
`timescale 1ns/1ns
`default_nettype none
`include "vcfg_consts.vh"
module volatile_config_wrap_dummy #(
  parameter AW = 24
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // serial pins
  input  wire          sckPin,
  input  wire          csPin_n,
  input  wire          dqInPin,
  output reg           dqOut_r,
  output reg           dqOe_rn,
  // array read port
  output reg  [AW-1:0] memAddr_r,
  input  wire [7:0]    memData,
  // nonvolatile defaults and active state
  input  wire [7:0]    nvConfig,
  output reg  [7:0]    cfgActive_r,
  output reg           execInPlace_r
);
  localparam [2:0] ST_OPC   = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_DUMMY = 3'h2;
  localparam [2:0] ST_DATA  = 3'h3;
  localparam [2:0] ST_WCFG  = 3'h4;
  localparam [2:0] ST_SKIP  = 3'h5;
  localparam [1:0] SRC_MEM  = 2'h0;
  localparam [1:0] SRC_CFG  = 2'h1;
  localparam [1:0] SRC_TUNE = 2'h2;
  // tuning byte as a sized vector so single bits can be picked
  localparam [7:0] TUNE_BYTE = `TUNE_PATTERN;

  wire [2:0] pinLevel;
  wire       sck = pinLevel[2];
  wire       csN = pinLevel[1];
  wire       dqIn = pinLevel[0];

  reg  [2:0]    state_r;
  reg  [4:0]    bitCnt_r;
  reg  [7:0]    inShift_r;
  reg  [7:0]    outShift_r;
  reg  [2:0]    outCnt_r;
  reg  [1:0]    src_r;
  reg  [3:0]    dummyLeft_r;
  reg  [AW-1:0] addrShift_r;
  reg           sckPrev_r;
  reg           loadNv_r;
  reg           inPlaceHold_r;
  reg           isFast_r;

  wire sckRise = sck & ~sckPrev_r;
  wire sckFall = ~sck & sckPrev_r;
  wire [7:0] inByte = {inShift_r[6:0], dqIn};

  pin_sync #(.W(3), .INIT(`PIN_IDLE)) u_sync (
    .clk        (clk),
    .rst_n      (rst_n),
    .pinRaw     ({sckPin, csPin_n, dqInPin}),
    .pinLevel_r (pinLevel)
  );

  function [3:0] dummyCount;
    input [3:0] code;
    begin
      if (code == 4'h0 || code == 4'hF)
        dummyCount = `DUMMY_DEFAULT;
      else
        dummyCount = code;
    end
  endfunction

  // next read address; wrap keeps upper bits so block stays aligned
  function [AW-1:0] nextAddr;
    input [AW-1:0] a;
    input [1:0]    wrap;
    begin
      case (wrap)
        `WRAP_16: nextAddr = {a[AW-1:4], a[3:0] + 4'h1};
        `WRAP_32: nextAddr = {a[AW-1:5], a[4:0] + 5'h01};
        `WRAP_64: nextAddr = {a[AW-1:6], a[5:0] + 6'h01};
        default:  nextAddr = a + {{(AW-1){1'b0}}, 1'b1};
      endcase
    end
  endfunction

  // frame engine; bit events come from sampled sck edges, frame end from the sampled csN level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= ST_OPC;
      bitCnt_r      <= 5'h00;
      inShift_r     <= 8'h00;
      outShift_r    <= 8'h00;
      outCnt_r      <= 3'h0;
      src_r         <= SRC_MEM;
      dummyLeft_r   <= 4'h0;
      addrShift_r   <= {AW{1'b0}};
      memAddr_r     <= {AW{1'b0}};
      sckPrev_r     <= 1'b0;
      dqOut_r       <= 1'b0;
      dqOe_rn       <= 1'b1;
      cfgActive_r   <= `CFG_RESET;
      execInPlace_r <= 1'b0;
      loadNv_r      <= 1'b1;
      inPlaceHold_r <= 1'b0;
      isFast_r      <= 1'b0;
    end else begin
      sckPrev_r <= sck;
      if (loadNv_r) begin
        loadNv_r      <= 1'b0;
        cfgActive_r   <= nvConfig & ~(8'h01 << `RSVD_BIT);
        execInPlace_r <= 1'b0;
      end else if (csN) begin
        // frame over: release the line and rearm
        dqOe_rn  <= 1'b1;
        bitCnt_r <= 5'h00;
        // stay in place mode only if enabled and confirmed
        if (isFast_r)
          execInPlace_r <= inPlaceHold_r;
        isFast_r <= 1'b0;
        state_r  <= (isFast_r ? inPlaceHold_r : execInPlace_r) ? ST_ADDR : ST_OPC;
        if (state_r == ST_WCFG && bitCnt_r == `OP_BITS) begin
          cfgActive_r <= inShift_r & ~(8'h01 << `RSVD_BIT);
        end
      end else begin
        if (sckRise) begin
          inShift_r <= inByte;
          case (state_r)
            ST_OPC: begin
              bitCnt_r <= bitCnt_r + 5'h01;
              if (bitCnt_r == `OP_BITS - 5'h01) begin
                bitCnt_r <= 5'h00;
                case (inByte)
                  `OP_WR_VCFG: state_r <= ST_WCFG;
                  `OP_RD_VCFG: begin
                    state_r  <= ST_DATA;
                    src_r    <= SRC_CFG;
                    outCnt_r <= 3'h0;
                  end
                  `OP_FAST_READ: begin
                    state_r  <= ST_ADDR;
                    src_r    <= SRC_MEM;
                    isFast_r <= 1'b1;
                  end
                  `OP_TUNE_READ: begin
                    state_r <= ST_ADDR;
                    src_r   <= SRC_TUNE;
                  end
                  default: state_r <= ST_SKIP;
                endcase
              end
            end
            ST_ADDR: begin
              bitCnt_r    <= bitCnt_r + 5'h01;
              addrShift_r <= {addrShift_r[AW-2:0], dqIn};
              if (execInPlace_r && bitCnt_r == 5'h00) begin
                isFast_r <= 1'b1;
                src_r    <= SRC_MEM;
              end
              if (bitCnt_r == `ADDR_BITS - 5'h01) begin
                // dummy phase after last address clock
                state_r     <= ST_DUMMY;
                memAddr_r   <= {addrShift_r[AW-2:0], dqIn};
                dummyLeft_r <= dummyCount(cfgActive_r[`DUMMY_MSB:`DUMMY_LSB]);
                bitCnt_r    <= 5'h00;
              end
            end
            ST_DUMMY: begin
              // first dummy bit low confirms in-place mode
              if (bitCnt_r == 5'h00)
                inPlaceHold_r <= ~cfgActive_r[`IN_PLACE_BIT] & ~dqIn;
              bitCnt_r    <= 5'h01;
              dummyLeft_r <= dummyLeft_r - 4'h1;
              if (dummyLeft_r == 4'h1) begin
                state_r  <= ST_DATA;
                outCnt_r <= 3'h0;
              end
            end
            ST_WCFG: begin
              if (bitCnt_r != `OP_BITS)
                bitCnt_r <= bitCnt_r + 5'h01;
            end
            default: ;
          endcase
        end
        if (sckFall && state_r == ST_DATA) begin
          // line driven only once data starts
          dqOe_rn  <= 1'b0;
          outCnt_r <= outCnt_r - 3'h1;
          if (outCnt_r == 3'h0) begin
            case (src_r)
              SRC_CFG: begin
                dqOut_r    <= cfgActive_r[7];
                outShift_r <= {cfgActive_r[6:0], 1'b0};
              end
              SRC_TUNE: begin
                dqOut_r    <= TUNE_BYTE[7];
                outShift_r <= {TUNE_BYTE[6:0], 1'b0};
              end
              default: begin
                dqOut_r    <= memData[7];
                outShift_r <= {memData[6:0], 1'b0};
                memAddr_r  <= nextAddr(memAddr_r, cfgActive_r[`WRAP_MSB:`WRAP_LSB]);
              end
            endcase
          end else begin
            dqOut_r    <= outShift_r[7];
            outShift_r <= {outShift_r[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/vcfg_assertions.sv
// Purpose: port checks for the volatile configuration block
// Assumes: one clock domain, async active-low reset
// Notes:   wrap checks only see address steps inside a data phase
`timescale 1ns/1ns
`default_nettype none
module vcfg_assertions #(
  parameter AW = 24
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // pins
  input wire logic          sckPin,
  input wire logic          csPin_n,
  input wire logic          dqOe_rn,
  // state
  input wire logic [AW-1:0] memAddr_r,
  input wire logic [7:0]    nvConfig,
  input wire logic [7:0]    cfgActive_r,
  input wire logic          execInPlace_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // address step while the device keeps driving data
  sequence s_step(w);
    !dqOe_rn && !$past(dqOe_rn) && cfgActive_r[1:0] == w && memAddr_r != $past(memAddr_r);
  endsequence
  // margin lets the previous frame's enable drain through the synchroniser
  sequence s_start;
    $fell(csPin_n) ##8 1'b1;
  endsequence
  property p_rsvd; cfgActive_r[2] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_load; $rose(rst_n) |-> ##[1:2] cfgActive_r == (nvConfig & 8'hFB); endproperty
  a_load: assert property (p_load) else $error("defaults not reloaded");
  property p_idle; csPin_n [*8] |-> dqOe_rn; endproperty
  a_idle: assert property (p_idle) else $error("driving while deselected");
  property p_quiet; s_start |-> dqOe_rn [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("driving during opcode");
  property p_commit; !$stable(cfgActive_r) |-> dqOe_rn && !sckPin; endproperty
  a_commit: assert property (p_commit) else $error("config changed mid frame");
  property p_inPlace; $rose(execInPlace_r) |-> !cfgActive_r[3]; endproperty
  a_inPlace: assert property (p_inPlace) else $error("in-place while disabled");
  property p_wrap16;
    s_step(2'h0) |-> memAddr_r == {$past(memAddr_r[AW-1:4]), $past(memAddr_r[3:0]) + 4'h1};
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-byte wrap broken");
  property p_wrapCont; s_step(2'h3) |-> memAddr_r == $past(memAddr_r) + 1'b1; endproperty
  a_wrapCont: assert property (p_wrapCont) else $error("linear step broken");
endmodule
`default_nettype wire

// file: verification/spi_host.sv
// Purpose: serial host model in front of the configuration block
// Assumes: mode 0, 8 clk per serial bit, driven on falling clk
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/1ns
`default_nettype none
module spi_host (
  // clock and device data
  input  wire logic       clk,
  input  wire logic       dqOut,
  // serial pins
  output var  logic       sck,
  output var  logic       csN,
  output var  logic       dq,
  // received byte strobe
  output var  logic [7:0] rxByte,
  output var  logic       rxValid
);
  // idle pins: clock low, deselected
  initial begin
    {sck, csN, dq, rxValid, rxByte} = {3'h2, 1'h0, 8'h00};
  end
  // slow clock suits any dummy count
  task automatic bitx(input logic b);
    dq = b;
    repeat (4) @(negedge clk);
    sck = 1'b1;
    repeat (4) @(negedge clk);
    rxByte = {rxByte[6:0], dqOut};
    sck = 1'b0;
  endtask
  task automatic send(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) bitx(v[i]);
  endtask
  // data line toggled, ignored once dummies end
  task automatic recv(input int k);
    repeat (k) begin
      repeat (8) bitx(~dq);
      rxValid = 1'b1;
      @(negedge clk);
      rxValid = 1'b0;
    end
  endtask
  // frame edges, gap kept at 8 clk
  task automatic frame(input logic on);
    csN = !on;
    if (!on) dq = ~dq;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// Purpose: self-checking bench for the volatile configuration block
// Assumes: array model is an address hash, no write enable needed
// Notes:   expected bytes queued by stimulus, compared on rxValid
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk, rst_n, sck, csN, dq, dqOut, oeN, rxValid, inPlace, dqLine;
  logic [23:0] memAddr, a;
  logic [7:0]  memData, nvConfig, cfg, rxByte, want, wcfg;
  logic [31:0] seed;
  logic [7:0]  expQ[$];
  logic [3:0]  codes[4] = '{4'h0, 4'h1, 4'hE, 4'hF};
  int          span[4] = '{15, 31, 63, -1};
  int          miscompares, cmp_count, n;
  volatile_config_wrap_dummy #(.AW(24)) uut (.clk(clk), .rst_n(rst_n), .sckPin(sck),
    .csPin_n(csN), .dqInPin(dq), .dqOut_r(dqOut), .dqOe_rn(oeN), .memAddr_r(memAddr),
    .memData(memData), .nvConfig(nvConfig), .cfgActive_r(cfg), .execInPlace_r(inPlace));
  spi_host host (.clk(clk), .dqOut(dqLine), .sck(sck), .csN(csN), .dq(dq), .rxByte(rxByte),
    .rxValid(rxValid));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ x[23:16];
  endfunction
  // array model answers combinationally, well inside one clk
  assign memData = mem(memAddr);
  // released device line shows the inverse, so a late enable corrupts data
  assign dqLine = oeN ? ~dqOut : dqOut;
  always #50 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // opBits of zero gives an in-place frame that starts with the address
  task automatic cmd(input logic [7:0] op, input logic [63:0] arg,
                     input int bits, k, opBits = 8);
    host.frame(1'b1);
    host.send({56'h0, op}, opBits);
    host.send(arg, bits);
    host.recv(k);
    host.frame(1'b0);
  endtask
  // oldest note against each byte the host collects
  always @(posedge rxValid) begin
    want = expQ.pop_front();
    check(rxByte, want);
  end
  // run needs well under 1 ms
  initial begin
    #2000000;
    miscompares++;
    complete_run;
  end
  initial begin
    {clk, rst_n} = 2'h0;
    seed = 32'h8423;
    nvConfig = seed[7:0];
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    check(cfg, nvConfig & 8'hFB);
    // every wrap code, dummy codes at both ends, start at block end
    for (int w = 0; w < 4; w++) begin
      seed = lfsr(seed);
      wcfg = {codes[w], 2'h3, 2'(w)};
      cmd(8'h81, 64'(wcfg), 8, 0);
      expQ.push_back(wcfg & 8'hFB);
      cmd(8'h85, 64'h0, 0, 1);
      n = (codes[w] == 4'h0 || codes[w] == 4'hF) ? 8 : int'(codes[w]);
      a = {seed[23:6], 6'h3F};
      expQ.push_back(mem(a));
      expQ.push_back(mem(a - 24'(span[w])));
      cmd(8'h0B, (64'(a) << n) | ((64'h1 << n) - 64'h1), 24 + n, 2);
    end
    expQ.push_back(8'h5A);
    expQ.push_back(8'h5A);
    cmd(8'h5A, {32'h0, a, 8'hFF}, 32, 2);
    // mid-run reset reloads defaults, then one in-place round trip
    seed = lfsr(seed);
    rst_n = 1'b0;
    nvConfig = seed[7:0];
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    check(cfg, nvConfig & 8'hFB);
    cmd(8'h81, 64'h27, 8, 0);
    expQ.push_back(8'h23);
    cmd(8'h85, 64'h0, 0, 1);
    a = seed[31:8];
    expQ.push_back(mem(a));
    cmd(8'h0B, 64'(a) << 2, 26, 1);
    check({7'h0, inPlace}, 8'h01);
    expQ.push_back(mem(a));
    cmd(8'h00, (64'(a) << 2) | 64'h3, 26, 1, 0);
    check({7'h0, inPlace}, 8'h00);
    repeat (20) @(negedge clk);
    complete_run;
  end
endmodule
bind volatile_config_wrap_dummy vcfg_assertions #(.AW(AW)) chk (.clk(clk), .rst_n(rst_n),
  .sckPin(sckPin), .csPin_n(csPin_n), .dqOe_rn(dqOe_rn), .memAddr_r(memAddr_r),
  .nvConfig(nvConfig), .cfgActive_r(cfgActive_r), .execInPlace_r(execInPlace_r));
`default_nettype wire
